// *** hw/dwc_map.svh ***
// register offsets, field positions and reset values for the debug watch/claim bank
`ifndef DWC_MAP_SVH
`define DWC_MAP_SVH
`define DWC_ADDR_W 8
`define DWC_OFF_CLAIM_SET 8'h00
`define DWC_OFF_CLAIM_READ 8'h04
`define DWC_OFF_MDSC 8'h08
`define DWC_OFF_OSLOCK 8'h0c
`define DWC_OFF_WCR0 8'h10
`define DWC_WCR_MASK 32'h1fff_fffd
`define DWC_WCR_RESET 32'h0000_0000
`define DWC_MDSC_LOCKED_MASK 32'h6ce0_4040
`define DWC_MDSC_FREE_MASK 32'h0000_b001
`define DWC_MDSC_RESET 32'h0000_0000
`define DWC_CLAIM_RESET 8'h00
`define DWC_WCR_MASK_HI 28
`define DWC_WCR_MASK_LO 24
`define DWC_WCR_WT 20
`define DWC_WCR_LBN_HI 19
`define DWC_WCR_LBN_LO 16
`define DWC_WCR_SSC_HI 15
`define DWC_WCR_SSC_LO 14
`define DWC_WCR_HMC 13
`define DWC_WCR_BAS_HI 12
`define DWC_WCR_BAS_LO 5
`define DWC_WCR_LSC_HI 4
`define DWC_WCR_LSC_LO 3
`define DWC_WCR_PAC_HI 2
`define DWC_WCR_PAC_LO 1
`define DWC_WCR_EN 0
`define DWC_MDSC_MDE 15
`define DWC_MDSC_KDE 13
`define DWC_MDSC_COMMS_CHANNEL_TRAP 12
`define DWC_MDSC_SS 0
`endif

// *** hw/dwc_pkg.sv ***
// types for the debug watch/claim bank
package dwc_pkg;
  typedef logic [31:0] dwc_word_t;
  typedef logic [1:0] dwc_idx_t;
endpackage

// *** hw/dwc_wcr_mem.sv ***
// four-entry watchpoint control store with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "dwc_map.svh"
module dwc_wcr_mem (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic we_i,
  input wire dwc_pkg::dwc_idx_t waddr_i,
  input wire dwc_pkg::dwc_word_t wdata_i,
  input wire dwc_pkg::dwc_idx_t raddr_i,
  output dwc_pkg::dwc_word_t rdata_o,
  output logic [127:0] all_o
);
  typedef struct packed {
    logic [3:0][31:0] mem;
    logic [31:0] rd;
  } dwc_mem_s;
  dwc_mem_s s_q, s_d;
  always_comb begin
    s_d = s_q;
    if (we_i) begin
      s_d.mem[waddr_i] = wdata_i & `DWC_WCR_MASK;
    end
    s_d.rd = s_q.mem[raddr_i];
  end
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
  assign rdata_o = s_q.rd;
  assign all_o = s_q.mem;
endmodule
`default_nettype wire

// *** hw/dwc_top.sv ***
// debug watch/claim control register bank
`timescale 1ns/1ps
`default_nettype none
`include "dwc_map.svh"
module dwc_top (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic debug_state_i,
  input wire logic el_unpriv_i,
  input wire logic eld_in_use_i,
  output logic [31:0] rdata_o,
  output logic [7:0] claim_tags_o,
  output logic os_lock_set_o,
  output logic monitor_events_enable_o,
  output logic kernel_debug_enable_o,
  output logic software_step_o,
  output logic comms_trap_o,
  output logic [3:0] wp_active_o,
  output logic [3:0] wp_linked_o
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [7:0] claim;
    logic os_lock_set;
    logic [31:0] mdsc;
    logic [31:0] rdata;
    logic monitor_events_enable;
    logic kernel_debug_enable;
    logic ss;
    logic trap;
    logic [3:0] act;
    logic [3:0] lnk;
  } dwc_top_s;
  dwc_top_s s_q, s_d;
  logic [127:0] wcr_all;
  logic wcr_we;
  logic [31:0] wmask;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_wcr(input logic [7:0] a);
    is_wcr = (a[7:4] == 4'(`DWC_OFF_WCR0 >> 4)) && (a[1:0] == 2'h0);
  endfunction

  // watchpoint live: enabled and access type not reserved
  function automatic logic wp_live(input logic [31:0] w);
    wp_live = w[`DWC_WCR_EN] && (w[`DWC_WCR_LSC_HI:`DWC_WCR_LSC_LO] != 2'h0);
  endfunction

  // mask 1 or 2 is reserved
  function automatic logic mask_ok(input logic [31:0] w);
    logic [4:0] m;
    m = w[`DWC_WCR_MASK_HI:`DWC_WCR_MASK_LO];
    mask_ok = (m != 5'h01) && (m != 5'h02);
  endfunction

  assign wcr_we = wr_i && is_wcr(addr_i);
  dwc_wcr_mem u_wcr (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .we_i(wcr_we),
    .waddr_i(addr_i[3:2]),
    .wdata_i(wdata_i),
    .raddr_i(addr_i[3:2]),
    .rdata_o(),
    .all_o(wcr_all)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (wr_i && addr_i == `DWC_OFF_CLAIM_SET) begin
      s_d.claim = s_q.claim | wdata_i[7:0];
    end
    if (wr_i && addr_i == `DWC_OFF_OSLOCK) begin
      s_d.os_lock_set = wdata_i[0];
    end
    wmask = `DWC_MDSC_FREE_MASK | (s_q.os_lock_set ? `DWC_MDSC_LOCKED_MASK : 32'h0);
    if (wr_i && addr_i == `DWC_OFF_MDSC) begin
      s_d.mdsc = (s_q.mdsc & ~wmask) | (wdata_i & wmask);
    end
    s_d.rdata = 32'h0;
    if (rd_i) begin
      case (addr_i)
        `DWC_OFF_CLAIM_READ: s_d.rdata = {24'h0, s_q.claim};
        `DWC_OFF_MDSC: s_d.rdata = s_q.mdsc;
        `DWC_OFF_OSLOCK: s_d.rdata = {31'h0, s_q.os_lock_set};
        default: s_d.rdata = is_wcr(addr_i) ? wcr_all[addr_i[3:2] * 32 +: 32] : 32'h0;
      endcase
    end
    s_d.monitor_events_enable = s_q.mdsc[`DWC_MDSC_MDE];
    s_d.kernel_debug_enable = s_q.mdsc[`DWC_MDSC_KDE];
    s_d.ss = s_q.mdsc[`DWC_MDSC_SS] && eld_in_use_i;
    s_d.trap = s_q.mdsc[`DWC_MDSC_COMMS_CHANNEL_TRAP] && el_unpriv_i && !debug_state_i;
    for (int i = 0; i < 4; i++) begin
      s_d.act[i] = wp_live(wcr_all[i*32 +: 32]) && mask_ok(wcr_all[i*32 +: 32]);
      s_d.lnk[i] = wcr_all[i*32 + `DWC_WCR_WT];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign claim_tags_o = s_q.claim;
  assign os_lock_set_o = s_q.os_lock_set;
  assign monitor_events_enable_o = s_q.monitor_events_enable;
  assign kernel_debug_enable_o = s_q.kernel_debug_enable;
  assign software_step_o = s_q.ss;
  assign comms_trap_o = s_q.trap;
  assign wp_active_o = s_q.act;
  assign wp_linked_o = s_q.lnk;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence claim_write;
    wr_i && addr_i == `DWC_OFF_CLAIM_SET;
  endsequence
  a_claim_sets: assert property (claim_write |=> ((claim_tags_o & $past(wdata_i[7:0])) == $past(wdata_i[7:0]))) else $error("claim not set");
  a_claim_keeps: assert property (claim_write |=> ((claim_tags_o & $past(claim_tags_o)) == $past(claim_tags_o))) else $error("claim lost");
  a_res_zero: assert property (rd_i && addr_i == `DWC_OFF_MDSC |=> rdata_o[18:16] == 3'h0) else $error("reserved nonzero");
  a_lock_guard: assert property (!os_lock_set_o && wr_i && addr_i == `DWC_OFF_MDSC |=> s_q.mdsc[30:29] == $past(s_q.mdsc[30:29])) else $error("full copy changed unlocked");
  a_lock_other: assert property (!os_lock_set_o |=> s_q.mdsc[27:26] == $past(s_q.mdsc[27:26]) || $past(os_lock_set_o)) else $error("copy changed unlocked");
  a_mde_follow: assert property (monitor_events_enable_o == $past(s_q.mdsc[15])) else $error("mde mismatch");
  a_kde_follow: assert property (kernel_debug_enable_o == $past(s_q.mdsc[13])) else $error("kde mismatch");
  a_trap_dbg: assert property (debug_state_i |=> !comms_trap_o) else $error("trap in debug");
  a_step_gate: assert property (!eld_in_use_i |=> !software_step_o) else $error("step without level");
  a_wp_rsv: assert property (wp_active_o[0] |-> $past(wcr_all[0]) && $past(wcr_all[4:3]) != 2'h0) else $error("disabled wp active");
endmodule
`default_nettype wire

// *** bench/dwc_top_test.sv ***
// self-checking bench for the debug watch/claim bank
`timescale 1ns/1ps
`default_nettype none
`include "dwc_map.svh"
module dwc_top_test;
  logic clk_sys_i, resetn_i, wr_i, rd_i, dbg_i, unpriv_i, eld_i;
  logic [7:0] addr_i, tags;
  logic [31:0] wdata_i, rdata_o;
  logic lock, monitor_events_enable, kernel_debug_enable, ss, trap;
  logic [3:0] act, lnk;
  int mismatches, n_tests, cyc;
  dwc_top i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .debug_state_i(dbg_i),
    .el_unpriv_i(unpriv_i), .eld_in_use_i(eld_i), .rdata_o(rdata_o),
    .claim_tags_o(tags), .os_lock_set_o(lock), .monitor_events_enable_o(monitor_events_enable),
    .kernel_debug_enable_o(kernel_debug_enable), .software_step_o(ss), .comms_trap_o(trap),
    .wp_active_o(act), .wp_linked_o(lnk));
  // ****************
  // clock and watchdog
  // ****************
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 2000) begin
      mismatches++;
      wrap_up();
    end
  end
  // ****************
  // shared tasks
  // ****************
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic claim_t();
    wr(`DWC_OFF_CLAIM_SET, 32'hffff_ff05);
    rd(`DWC_OFF_CLAIM_READ, 32'h0000_0005);
    wr(`DWC_OFF_CLAIM_SET, 32'h0000_0030);
    wr(`DWC_OFF_CLAIM_SET, 32'h0000_0000);
    rd(`DWC_OFF_CLAIM_READ, 32'h0000_0035);
    rd(`DWC_OFF_CLAIM_SET, 32'h0000_0000);
    chk({24'h0, tags}, 32'h0000_0035);
    rd(8'h40, 32'h0000_0000);
  endtask
  task automatic wcr_t(input logic [31:0] v[4], input logic [3:0] ea, input logic [3:0] el);
    for (int i = 0; i < 4; i++) wr(`DWC_OFF_WCR0 + 8'(4 * i), v[i]);
    for (int i = 0; i < 4; i++) rd(`DWC_OFF_WCR0 + 8'(4 * i), v[i] & `DWC_WCR_MASK);
    idle(3);
    chk({28'h0, act}, {28'h0, ea});
    chk({28'h0, lnk}, {28'h0, el});
  endtask
  task automatic mdsc_t();
    eld_i <= 1'b1;
    unpriv_i <= 1'b1;
    wr(`DWC_OFF_MDSC, 32'hffff_ffff);
    rd(`DWC_OFF_MDSC, `DWC_MDSC_FREE_MASK);
    idle(2);
    chk({28'h0, monitor_events_enable, kernel_debug_enable, ss, trap}, 32'h0000_000f);
    eld_i <= 1'b0;
    unpriv_i <= 1'b0;
    idle(3);
    chk({28'h0, monitor_events_enable, kernel_debug_enable, ss, trap}, 32'h0000_000c);
    wr(`DWC_OFF_OSLOCK, 32'h0000_0001);
    rd(`DWC_OFF_OSLOCK, 32'h0000_0001);
    wr(`DWC_OFF_MDSC, 32'hffff_ffff);
    rd(`DWC_OFF_MDSC, `DWC_MDSC_LOCKED_MASK | `DWC_MDSC_FREE_MASK);
    wr(`DWC_OFF_OSLOCK, 32'h0000_0000);
    wr(`DWC_OFF_MDSC, 32'h0000_0000);
    rd(`DWC_OFF_MDSC, `DWC_MDSC_LOCKED_MASK);
    idle(2);
    chk({31'h0, monitor_events_enable | lock}, 32'h0000_0000);
    wr(`DWC_OFF_MDSC, 32'h0000_1000);
    unpriv_i <= 1'b1;
    dbg_i <= 1'b1;
    idle(3);
    chk({31'h0, trap}, 32'h0000_0000);
    dbg_i <= 1'b0;
    idle(3);
    chk({31'h0, trap}, 32'h0000_0001);
  endtask
  task automatic reset_t();
    resetn_i <= 1'b0;
    idle(4);
    resetn_i <= 1'b1;
    #1 chk({tags, lock, monitor_events_enable, kernel_debug_enable, ss, trap, act, lnk}, 21'h0);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    {resetn_i, wr_i, rd_i, dbg_i, unpriv_i, eld_i} = 6'h0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    idle(4);
    resetn_i <= 1'b1;
    claim_t();
    wcr_t('{32'hffff_ffff, 32'h0100_0019, 32'h0000_0001, 32'h0000_0018}, 4'h1, 4'h1);
    wcr_t('{32'h0000_0019, 32'h0300_0009, 32'h0010_0011, 32'h0000_0019}, 4'hf, 4'h4);
    mdsc_t();
    dbg_i <= 1'b1;
    reset_t();
    wrap_up();
  end
endmodule
`default_nettype wire
